// ### hw/pmx_port.sv
// Notes on behaviour
// [RULE_01] with auto crossover on and no link, swap transmit and receive pairs
// [RULE_02] crossover can be turned off by its pin or register 19 bits 9:8
// [RULE_03] crossover runs apart from auto-negotiation and settles before it starts
// [RULE_04] frames cross the MAC side as four-bit nibbles, separate tx and rx paths
// [RULE_05] MAC side runs at 10 or 100 Mb/s as the mode selects
// [RULE_06] transmit path has no error input: nibble, enable and clock only
// [RULE_07] the port sources both transmit and receive clocks
// [RULE_08] half duplex: carrier sense while transmitting or receiving
// [RULE_09] half duplex: collision when receiving during a transmission
// [RULE_10] full duplex: carrier sense on receive only, collision held low
// [RULE_11] during power-on reset MII outputs and pair drivers are released
// [RULE_12] after the reset process MII and pair drivers are enabled again
// [RULE_13] management uses one two-way data line plus an input clock
// [RULE_14] every management transfer is timed by the management clock
// [RULE_15] management pins stay active in every MAC mode and rate
// [RULE_16] one consolidated status register gives key status in one read
// [RULE_17] MII clocks run at 25 MHz for 100 Mb/s, 2.5 MHz for 10 Mb/s
// [RULE_18] a strapped phy address of zero keeps MII outputs released
// [RULE_19] MAC changes tx signals after the tx clock rise; sampled on rising edge
// [RULE_20] while searching, alternate pair assignment after a fixed interval
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/100ps
module pmx_port
   import pmx_pkg::*;
#(
   parameter int XOVER_SWAP_CYC = XOVER_SWAP_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [3:0] mii_txd,
   input wire logic mii_tx_en,
   output logic mii_tx_clk,
   output logic mii_rx_clk,
   output pmx_rx_nib_type mii_rx,
   output logic mii_crs,
   output logic mii_col,
   output logic mii_oe,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic crossover_auto_enable_pin,
   input wire logic [4:0] strap_addr,
   input wire logic line_link_up,
   input wire logic line_rx_crs,
   input wire logic line_rx_strobe,
   input wire pmx_rx_nib_type line_rx,
   output logic line_tx_strobe,
   output pmx_tx_nib_type line_tx,
   output logic pair_tx_oe,
   output logic pair_mdix_sel,
   output logic autoneg_enable,
   output logic speed_100,
   output logic full_duplex
);
   localparam int SYNC_W = 14;
   localparam int ISO_W = $clog2(ISO_CYCLES + 1);
   localparam int SWAP_W = $clog2(XOVER_SWAP_CYC + 1);
   localparam int SET_W = $clog2(XOVER_SETTLE_CYCLES + 1);

   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] s1_r;
   logic [SYNC_W-1:0] s2_r;
   logic [SYNC_W-1:0] clean_r;
   logic [SYNC_W-1:0] s3_r;
   logic mdc_s;
   logic mdio_s;
   logic xpin_s;
   logic link_s;
   logic txen_s;
   logic [3:0] txd_s;
   logic [4:0] strap_s;
   logic mdc_prev_r;
   logic mdc_rise;
   logic iso_r;
   logic [ISO_W-1:0] iso_cnt_r;
   logic [4:0] phy_addr_r;
   logic mii_live;
   logic [15:0] ctrl_r;
   logic [15:0] xctl_r;
   logic [4:0] div_cnt_r;
   logic [4:0] div_half;
   logic mii_clk_r;
   logic rise_en;
   logic fall_en;
   logic tx_active_r;
   pmx_rx_nib_type rx_pend_r;
   logic xover_auto;
   logic mdix_r;
   logic mdix_prev_r;
   logic [SWAP_W-1:0] swap_cnt_r;
   logic [SET_W-1:0] settle_cnt_r;
   logic [15:0] cstat;
   logic [4:0] bus_idx;
   logic bus_map;
   logic [4:0] md_idx;
   logic md_wr;
   logic [15:0] md_wdata;
   logic [15:0] md_rdata;

   // pin inputs pass three flops and a held fourth; a change counts once stages two and three agree
   assign raw_in = {strap_addr, mii_txd, mii_tx_en, line_link_up,
                    crossover_auto_enable_pin, mdio_in, mdc};
   generate
      for (genvar i = 0; i < SYNC_W; i++)
      begin : g_sync
         always_ff @(posedge sys_clk)
         begin
            if (rst)
            begin
               s1_r[i] <= 1'b0;
               s2_r[i] <= 1'b0;
               s3_r[i] <= 1'b0;
               clean_r[i] <= 1'b0;
            end
            else
            begin
               s1_r[i] <= raw_in[i];
               s2_r[i] <= s1_r[i];
               s3_r[i] <= s2_r[i];
               if (s2_r[i] == s3_r[i])
                  clean_r[i] <= s3_r[i];
            end
         end
      end
   endgenerate
   assign mdc_s = clean_r[0];
   assign mdio_s = clean_r[1];
   assign xpin_s = clean_r[2];
   assign link_s = clean_r[3];
   assign txen_s = clean_r[4];
   assign txd_s = clean_r[8:5];
   assign strap_s = clean_r[13:9];

   // management clock edges found in the system domain
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         mdc_prev_r <= 1'b0;
      else
         mdc_prev_r <= mdc_s;
   end
   assign mdc_rise = mdc_s & ~mdc_prev_r;

   // reset process: hold isolation, then catch the address strap once
   // [RULE_11] isolate during reset
   // [RULE_12] re-enable after count
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         iso_r <= 1'b1;
         iso_cnt_r <= '0;
         phy_addr_r <= 5'h00;
      end
      else if (iso_r)
      begin
         iso_cnt_r <= iso_cnt_r + ISO_W'(1);
         if (iso_cnt_r == ISO_W'(ISO_CYCLES - 1))
         begin
            iso_r <= 1'b0;
            phy_addr_r <= strap_s;
         end
      end
   end
   // [RULE_18] address zero keeps MII off
   assign mii_live = ~iso_r & (phy_addr_r != 5'h00);
   assign mii_oe = mii_live;
   assign pair_tx_oe = ~iso_r;

   // mode bits come straight from the control register
   // [RULE_05] rate from mode
   assign speed_100 = ctrl_r[CTRL_SPEED_BIT];
   assign full_duplex = ctrl_r[CTRL_DUPLEX_BIT];

   // one divider feeds both MII clocks, so tx and rx are always in phase
   // [RULE_17] 25 or 2.5 MHz
   assign div_half = speed_100 ? 5'(HALF_FAST - 1) : 5'(HALF_SLOW - 1);
   assign rise_en = (div_cnt_r >= div_half) & ~mii_clk_r;
   assign fall_en = (div_cnt_r >= div_half) & mii_clk_r;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         div_cnt_r <= 5'h00;
         mii_clk_r <= 1'b0;
      end
      else if (div_cnt_r >= div_half)
      begin
         div_cnt_r <= 5'h00;
         mii_clk_r <= ~mii_clk_r;
      end
      else
         div_cnt_r <= div_cnt_r + 5'h01;
   end
   // [RULE_07] port drives both clocks
   assign mii_tx_clk = mii_clk_r;
   assign mii_rx_clk = mii_clk_r;

   // transmit nibble taken at our own clock rise; the MAC moved after the last one
   // [RULE_19] sample at rising edge
   // [RULE_06] no error input taken
   always_ff @(posedge sys_clk)
   begin
      line_tx_strobe <= 1'b0;
      if (rst)
      begin
         line_tx <= '0;
         tx_active_r <= 1'b0;
      end
      else if (!mii_live)
         tx_active_r <= 1'b0;
      else if (rise_en)
      begin
         // [RULE_04] nibble toward line
         line_tx <= '{data: txd_s, en: txen_s};
         line_tx_strobe <= 1'b1;
         tx_active_r <= txen_s;
      end
   end

   // receive nibble parked until the falling clock edge so the MAC sees it settled
   // [RULE_04] nibble toward MAC
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         rx_pend_r <= '0;
         mii_rx <= '0;
      end
      else
      begin
         if (line_rx_strobe)
            rx_pend_r <= line_rx;
         if (!mii_live)
            mii_rx <= '0;
         else if (fall_en)
            mii_rx <= rx_pend_r;
      end
   end

   // carrier sense and collision by duplex mode
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         mii_crs <= 1'b0;
         mii_col <= 1'b0;
      end
      else if (full_duplex)
      begin
         // [RULE_10] receive only, no collision
         mii_crs <= line_rx_crs;
         mii_col <= 1'b0;
      end
      else
      begin
         // [RULE_08] tx or rx activity
         mii_crs <= line_rx_crs | tx_active_r;
         // [RULE_09] rx during tx
         mii_col <= line_rx_crs & tx_active_r;
      end
   end

   // crossover search; the pin and the register bit must both allow it
   // [RULE_02] pin or register disable
   assign xover_auto = xpin_s & xctl_r[XCTL_AUTO_BIT];
   // [RULE_01] swap pairs without link
   // [RULE_20] fixed swap interval
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         mdix_r <= 1'b0;
         swap_cnt_r <= '0;
      end
      else if (!xover_auto)
      begin
         mdix_r <= xctl_r[XCTL_MANUAL_BIT];
         swap_cnt_r <= '0;
      end
      else if (link_s)
         swap_cnt_r <= '0;
      else if (swap_cnt_r == SWAP_W'(XOVER_SWAP_CYC - 1))
      begin
         mdix_r <= ~mdix_r;
         swap_cnt_r <= '0;
      end
      else
         swap_cnt_r <= swap_cnt_r + SWAP_W'(1);
   end
   assign pair_mdix_sel = mdix_r;

   // negotiation waits until a pair choice has stood for the settle time
   // [RULE_03] selection before negotiation
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         mdix_prev_r <= 1'b0;
         settle_cnt_r <= '0;
      end
      else
      begin
         mdix_prev_r <= mdix_r;
         if (mdix_r != mdix_prev_r)
            settle_cnt_r <= '0;
         else if (settle_cnt_r != SET_W'(XOVER_SETTLE_CYCLES))
            settle_cnt_r <= settle_cnt_r + SET_W'(1);
      end
   end
   assign autoneg_enable = ctrl_r[CTRL_AN_BIT] & ~iso_r & (mdix_r == mdix_prev_r)
                           & (settle_cnt_r == SET_W'(XOVER_SETTLE_CYCLES));

   // [RULE_16] one-read status word
   assign cstat = {8'h00, xover_auto, mii_col, mii_crs, autoneg_enable, mdix_r,
                   full_duplex, speed_100, link_s};

   function automatic logic [15:0] reg_value(input logic [4:0] idx);
      logic [15:0] v;
      v = 16'h0000;
      case (idx)
         REG_CTRL_IDX: v = ctrl_r;
         REG_STAT_IDX: v[STAT_LINK_BIT] = link_s;
         REG_CSTAT_IDX: v = cstat;
         REG_XCTL_IDX: v = xctl_r;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // plain register port: word aligned, upper half unmapped and reads zero
   assign bus_idx = reg_addr[6:2];
   assign bus_map = (reg_addr[1:0] == 2'h0) & ~reg_addr[7];
   always_comb md_rdata = reg_value(md_idx);
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         reg_rdata <= 16'h0000;
      else if (reg_rd && bus_map)
         reg_rdata <= reg_value(bus_idx);
      else
         reg_rdata <= 16'h0000;
   end

   // writes from management frames first, so the plain port wins a same-cycle clash
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ctrl_r <= CTRL_RESET;
         xctl_r <= XCTL_RESET;
      end
      else
      begin
         if (md_wr && md_idx == REG_CTRL_IDX)
            ctrl_r <= md_wdata;
         if (md_wr && md_idx == REG_XCTL_IDX)
            xctl_r <= md_wdata & XCTL_WMASK;
         if (reg_wr && bus_map && bus_idx == REG_CTRL_IDX)
            ctrl_r <= reg_wdata;
         if (reg_wr && bus_map && bus_idx == REG_XCTL_IDX)
            xctl_r <= reg_wdata & XCTL_WMASK;
      end
   end

   // management port is never gated by isolation or MAC mode
   // [RULE_15] always active
   pmx_mdio_slave u_mdio (
      .sys_clk(sys_clk),
      .rst(rst),
      .mdc_rise(mdc_rise),
      .mdio_in(mdio_s),
      .phy_addr(phy_addr_r),
      .reg_rdata(md_rdata),
      .reg_idx(md_idx),
      .reg_wr(md_wr),
      .reg_wdata(md_wdata),
      .mdio_out(mdio_out),
      .mdio_oe(mdio_oe)
   );

   // checks on the port behaviour
   iso_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_11]
      $fell(rst) |-> (!pair_tx_oe && !mii_oe) [*8])
      else $error("drivers enabled during reset process");
   iso_release_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_12]
      $fell(iso_r) |-> pair_tx_oe && (mii_oe == (phy_addr_r != 5'h00)))
      else $error("drivers not enabled after reset process");
   addr_zero_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_18]
      (phy_addr_r == 5'h00) |-> !mii_oe && (mii_rx == '0))
      else $error("MII driven with address zero");
   full_col_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_10]
      full_duplex |=> !mii_col && (mii_crs == $past(line_rx_crs)))
      else $error("full duplex carrier or collision wrong");
   half_crs_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_08]
      !full_duplex && tx_active_r |=> mii_crs)
      else $error("no carrier while transmitting");
   half_col_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_09]
      !full_duplex && tx_active_r && line_rx_crs |=> mii_col)
      else $error("collision missed");
   fast_clk_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_17]
      $rose(mii_tx_clk) && speed_100 |-> ##4 ($rose(mii_tx_clk) || !speed_100))
      else $error("fast clock period wrong");
   slow_clk_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_17]
      $rose(mii_tx_clk) && !speed_100 |-> ##40 ($rose(mii_tx_clk) || speed_100))
      else $error("slow clock period wrong");
   link_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_01]
      link_s && xover_auto && $past(xover_auto) |=> $stable(mdix_r))
      else $error("pairs swapped with link up");
   an_wait_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_03]
      $changed(mdix_r) |-> !autoneg_enable ##1 !autoneg_enable)
      else $error("negotiation during pair change");
   tx_sample_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_19]
      rise_en && mii_live |=> line_tx_strobe && line_tx.en == $past(txen_s))
      else $error("transmit nibble not taken at clock rise");
   cstat_read_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_16]
      reg_rd && bus_map && bus_idx == REG_CSTAT_IDX |=> reg_rdata == $past(cstat))
      else $error("consolidated status read wrong");
   swap_c: cover property (@(posedge sys_clk) disable iff (rst) $changed(mdix_r));
   col_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(mii_col));
   md_wr_c: cover property (@(posedge sys_clk) disable iff (rst) md_wr);
   md_rd_c: cover property (@(posedge sys_clk) disable iff (rst) $fell(mdio_oe));
endmodule // pmx_port

// ### common/pmx_pkg.sv
package pmx_pkg;
   // clock rates in kHz; the system clock is 100 MHz
   localparam int SYS_KHZ = 100000;
   localparam int MII_FAST_KHZ = 25000;
   localparam int MII_SLOW_KHZ = 2500;
   localparam int HALF_FAST = SYS_KHZ / (2 * MII_FAST_KHZ);
   localparam int HALF_SLOW = SYS_KHZ / (2 * MII_SLOW_KHZ);
   // isolation after reset, pair swap interval and settle time
   localparam int ISO_TIME_US = 10;
   localparam int ISO_CYCLES = ISO_TIME_US * SYS_KHZ / 1000;
   localparam int XOVER_SWAP_MS = 100;
   localparam int XOVER_SWAP_CYCLES = XOVER_SWAP_MS * SYS_KHZ;
   localparam int XOVER_SETTLE_US = 20;
   localparam int XOVER_SETTLE_CYCLES = XOVER_SETTLE_US * SYS_KHZ / 1000;
   // management register indices; byte address is four times the index
   localparam logic [4:0] REG_CTRL_IDX = 5'h00;
   localparam logic [4:0] REG_STAT_IDX = 5'h01;
   localparam logic [4:0] REG_CSTAT_IDX = 5'h11;
   localparam logic [4:0] REG_XCTL_IDX = 5'h13;
   // field positions
   localparam int CTRL_SPEED_BIT = 13;
   localparam int CTRL_AN_BIT = 12;
   localparam int CTRL_DUPLEX_BIT = 8;
   localparam int STAT_LINK_BIT = 2;
   localparam int XCTL_AUTO_BIT = 9;
   localparam int XCTL_MANUAL_BIT = 8;
   localparam logic [15:0] XCTL_WMASK = 16'h0300;
   // reset values
   localparam logic [15:0] CTRL_RESET = 16'h3000;
   localparam logic [15:0] XCTL_RESET = 16'h0200;
   // management frame
   localparam logic [1:0] MD_OP_RD = 2'h2;
   localparam logic [1:0] MD_OP_WR = 2'h1;
   localparam logic [4:0] MD_HDR_LAST = 5'h0b;
   localparam logic [4:0] MD_DATA_LAST = 5'h0f;
   typedef enum logic [2:0] {
      PMX_MD_IDLE = 3'h0,
      PMX_MD_START = 3'h1,
      PMX_MD_HDR = 3'h3,
      PMX_MD_TURN = 3'h2,
      PMX_MD_DATA = 3'h6
   } pmx_md_state_type;
   typedef struct packed {
      logic [3:0] data;
      logic dv;
      logic er;
   } pmx_rx_nib_type;
   typedef struct packed {
      logic [3:0] data;
      logic en;
   } pmx_tx_nib_type;
endpackage

// ### hw/pmx_mdio_slave.sv
`timescale 1ns/100ps
module pmx_mdio_slave
   import pmx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic mdc_rise,
   input wire logic mdio_in,
   input wire logic [4:0] phy_addr,
   input wire logic [15:0] reg_rdata,
   output logic [4:0] reg_idx,
   output logic reg_wr,
   output logic [15:0] reg_wdata,
   output logic mdio_out,
   output logic mdio_oe
);
   pmx_md_state_type state_r;
   logic [4:0] cnt_r;
   logic [11:0] hdr_r;
   logic [11:0] hdr_nxt;
   logic [15:0] shift_r;
   logic rd_r;
   logic wr_r;

   assign hdr_nxt = {hdr_r[10:0], mdio_in};

   // [RULE_13] frame decoding
   // every step below moves only on a rising edge of the management clock
   // [RULE_14] clocked by mdc
   always_ff @(posedge sys_clk)
   begin
      reg_wr <= 1'b0;
      if (rst)
      begin
         state_r <= PMX_MD_IDLE;
         cnt_r <= 5'h00;
         hdr_r <= 12'h000;
         shift_r <= 16'h0000;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         reg_idx <= 5'h00;
         reg_wdata <= 16'h0000;
         mdio_out <= 1'b0;
         mdio_oe <= 1'b0;
      end
      else if (mdc_rise)
      begin
         case (state_r)
            PMX_MD_IDLE:
            begin
               // preamble ones are skipped; the first zero opens a frame
               if (!mdio_in)
                  state_r <= PMX_MD_START;
            end
            PMX_MD_START:
            begin
               cnt_r <= 5'h00;
               state_r <= mdio_in ? PMX_MD_HDR : PMX_MD_IDLE;
            end
            PMX_MD_HDR:
            begin
               hdr_r <= hdr_nxt;
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == MD_HDR_LAST)
               begin
                  // op, phy address and register index are complete
                  rd_r <= (hdr_nxt[11:10] == MD_OP_RD) && (hdr_nxt[9:5] == phy_addr);
                  wr_r <= (hdr_nxt[11:10] == MD_OP_WR) && (hdr_nxt[9:5] == phy_addr);
                  reg_idx <= hdr_nxt[4:0];
                  cnt_r <= 5'h00;
                  state_r <= PMX_MD_TURN;
               end
            end
            PMX_MD_TURN:
            begin
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == 5'h00)
               begin
                  // second turnaround bit: drive zero and latch read data
                  shift_r <= reg_rdata;
                  mdio_oe <= rd_r;
                  mdio_out <= 1'b0;
               end
               else
               begin
                  cnt_r <= 5'h00;
                  state_r <= PMX_MD_DATA;
                  if (rd_r)
                  begin
                     mdio_out <= shift_r[15];
                     shift_r <= {shift_r[14:0], 1'b0};
                  end
               end
            end
            PMX_MD_DATA:
            begin
               cnt_r <= cnt_r + 5'h01;
               if (rd_r)
               begin
                  mdio_out <= shift_r[15];
                  shift_r <= {shift_r[14:0], 1'b0};
               end
               else
                  shift_r <= {shift_r[14:0], mdio_in};
               if (cnt_r == MD_DATA_LAST)
               begin
                  mdio_oe <= 1'b0;
                  mdio_out <= 1'b0;
                  reg_wr <= wr_r;
                  reg_wdata <= {shift_r[14:0], mdio_in};
                  state_r <= PMX_MD_IDLE;
               end
            end
            default:
               state_r <= PMX_MD_IDLE;
         endcase
      end
   end
endmodule // pmx_mdio_slave

// ### dv/pmx_mac_model.sv
`timescale 1ns/100ps
// mac and station manager as seen from the port
module pmx_mac_model
   import pmx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic mii_tx_clk,
   input wire logic hold_en,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   output logic [3:0] mii_txd,
   output logic mii_tx_en,
   output logic mdc,
   output logic mdio_in
);
   logic [3:0] q[$];
   logic clk_q = 1'b0;
   logic sm_oe = 1'b0;
   logic sm_bit = 1'b1;
   // pull-up wins when neither side drives
   assign mdio_in = mdio_oe ? mdio_out : (sm_oe ? sm_bit : 1'b1);
   // mdc stands still outside frames
   initial
   begin
      mii_txd = 4'h0;
      mii_tx_en = 1'b0;
      mdc = 1'b0;
   end
   // next nibble right after the tx clock rise
   always @(posedge sys_clk)
   begin
      clk_q <= mii_tx_clk;
      if (mii_tx_clk && !clk_q)
      begin
         mii_tx_en <= hold_en || (q.size() > 0);
         mii_txd <= (q.size() > 0) ? q.pop_front() : ~mii_txd;  // idle data keeps moving
      end
   end
   // one frame; data moves while mdc is low
   task automatic frame(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
      logic [47:0] f;
      f = {16'hffff, 2'b01, op, pa, ra, 2'b10, wd};
      #3;
      for (int i = 47; i >= 0; i--)
      begin
         sm_oe = !(op == MD_OP_RD && i < 18);
         sm_bit = f[i];
         #80;
         mdc = 1'b1;
         if (i < 16)
            rd[i] = mdio_in;
         #80;
         mdc = 1'b0;
      end
      sm_oe = 1'b0;
   endtask
endmodule // pmx_mac_model

// ### dv/test_pmx_port.sv
`timescale 1ns/100ps
module test_pmx_port
   import pmx_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic hold = 1'b0;
   logic crossover_auto_enable_pin = 1'b1;
   logic line_link_up = 1'b0;
   logic line_rx_crs = 1'b0;
   logic line_rx_strobe = 1'b0;
   logic [4:0] strap_addr = 5'h05;
   pmx_rx_nib_type line_rx = '0;
   pmx_rx_nib_type mii_rx;
   pmx_tx_nib_type line_tx;
   logic [15:0] reg_rdata, d;
   logic [3:0] mii_txd;
   logic mii_tx_en, mii_tx_clk, mii_rx_clk, mii_crs, mii_col, mii_oe, mdc, mdio_in;
   logic mdio_out, mdio_oe, line_tx_strobe, pair_tx_oe, pair_mdix_sel, autoneg_enable;
   logic speed_100, full_duplex, s, chk_tx = 1'b0;
   logic [31:0] v;
   logic [3:0] exp_q[$];
   int mismatches = 0, checked = 0, seed = 78, tx_rises = 0, rx_rises = 0, flips = 0;

   pmx_port #(.XOVER_SWAP_CYC(200)) pmx_port_inst (.sys_clk, .rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .mii_txd, .mii_tx_en, .mii_tx_clk, .mii_rx_clk,
      .mii_rx, .mii_crs, .mii_col, .mii_oe, .mdc, .mdio_in, .mdio_out, .mdio_oe,
      .crossover_auto_enable_pin, .strap_addr, .line_link_up, .line_rx_crs,
      .line_rx_strobe, .line_rx, .line_tx_strobe, .line_tx, .pair_tx_oe, .pair_mdix_sel,
      .autoneg_enable, .speed_100, .full_duplex);
   pmx_mac_model pmx_mac_model_inst (.sys_clk, .mii_tx_clk, .hold_en(hold), .mdio_out,
      .mdio_oe, .mii_txd, .mii_tx_en, .mdc, .mdio_in);

   // 100 MHz system clock
   always #5 sys_clk = ~sys_clk;
   // edge counters for rate and pair checks
   always @(posedge mii_tx_clk) tx_rises++;
   always @(posedge mii_rx_clk) rx_rises++;
   always @(pair_mdix_sel) flips++;
   // enabled nibbles on the line side must follow the mac order
   always @(posedge sys_clk)
   begin
      if (chk_tx && line_tx_strobe && line_tx.en)
         chk(line_tx.data, exp_q.pop_front());
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checked %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] w);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= w;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] r);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 r = reg_rdata;
   endtask

   // a hang is cut off far beyond the expected 10.5k cycles
   initial
   begin
      #500000;
      mismatches++;
      report_and_stop();
   end

   initial
   begin
      cyc(4);
      chk(mii_oe, 0);
      chk(pair_tx_oe, 0);
      rst <= 1'b0;
      cyc(990);
      chk(pair_tx_oe, 0);
      cyc(20);
      chk(pair_tx_oe, 1);
      chk(mii_oe, 1);
      wr(8'h82, 16'h0000);
      rd(8'h00, d);
      chk(d, CTRL_RESET);
      rd(8'h81, d);
      chk(d, 16'h0000);
      rd(8'h4c, d);
      chk(d, XCTL_RESET);
      // clock rate follows the speed bit, both clocks alike
      for (int k = 1; k >= 0; k--)
      begin
         wr(8'h00, k ? 16'h1000 : CTRL_RESET);
         cyc(100);
         chk(speed_100, !k);
         tx_rises = 0;
         rx_rises = 0;
         cyc(400);
         chk(tx_rises, k ? 16'd10 : 16'd100);
         chk(rx_rises, k ? 16'd10 : 16'd100);
      end
      // random nibbles plus an all-ones corner
      chk_tx = 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         v = $random(seed);
         exp_q.push_back((i == 15) ? 4'hf : v[3:0]);
         pmx_mac_model_inst.q.push_back((i == 15) ? 4'hf : v[3:0]);
      end
      cyc(150);
      chk(exp_q.size(), 0);
      chk_tx = 1'b0;
      // every duplex, receive and transmit mix
      for (int k = 0; k < 8; k++)
      begin
         wr(8'h00, CTRL_RESET | (k[2] ? 16'h0100 : 16'h0000));
         hold <= k[0];
         line_rx_crs <= k[1];
         cyc(30);
         chk(full_duplex, k[2]);
         chk(mii_crs, k[1] | (k[0] & !k[2]));
         chk(mii_col, k[1] & k[0] & !k[2]);
      end
      hold <= 1'b0;
      line_rx_crs <= 1'b0;
      wr(8'h00, CTRL_RESET);
      // strobe placed just after a fall so the next fall is unambiguous
      for (int i = 0; i < 4; i++)
      begin
         v = $random(seed);
         @(negedge mii_rx_clk);
         @(posedge sys_clk);
         line_rx <= v[5:0];
         line_rx_strobe <= 1'b1;
         @(posedge sys_clk);
         line_rx_strobe <= 1'b0;
         @(negedge mii_rx_clk);
         #1;
         chk(mii_rx, v[5:0]);
      end
      // no link: pairs alternate while negotiation waits
      flips = 0;
      cyc(450);
      chk(flips > 1, 1);
      chk(autoneg_enable, 0);
      line_link_up <= 1'b1;
      cyc(50);
      s = pair_mdix_sel;
      cyc(2100);
      chk(pair_mdix_sel, s);
      chk(autoneg_enable, 1);
      rd(8'h04, d);
      chk(d, 16'h0004);
      pmx_mac_model_inst.frame(MD_OP_RD, strap_addr, REG_CSTAT_IDX, 16'h0000, d);
      chk(d[7:0], {1'b1, 2'b00, 1'b1, s, 1'b0, 2'b11});
      pmx_mac_model_inst.frame(MD_OP_RD, strap_addr, REG_CTRL_IDX, 16'h0000, d);
      chk(d, CTRL_RESET);
      // managed write, then frames meant for another address
      pmx_mac_model_inst.frame(MD_OP_WR, strap_addr, REG_XCTL_IDX, 16'h0100, d);
      pmx_mac_model_inst.frame(MD_OP_WR, ~strap_addr, REG_XCTL_IDX, 16'h0000, d);
      pmx_mac_model_inst.frame(MD_OP_RD, ~strap_addr, REG_XCTL_IDX, 16'h0000, d);
      chk(d, 16'hffff);
      rd(8'h4c, d);
      chk(d, 16'h0100);
      chk(pair_mdix_sel, 1);
      // pin off overrides the auto bit even with no link
      crossover_auto_enable_pin <= 1'b0;
      wr(8'h4c, 16'hffff);
      rd(8'h4c, d);
      chk(d, XCTL_WMASK);
      line_link_up <= 1'b0;
      wr(8'h4c, XCTL_RESET);
      flips = 0;
      cyc(450);
      chk(flips, 1);
      chk(pair_mdix_sel, 0);
      // address zero at the strap keeps the mii side released
      strap_addr <= 5'h00;
      rst <= 1'b1;
      cyc(4);
      rst <= 1'b0;
      cyc(1100);
      chk(mii_oe, 0);
      chk(pair_tx_oe, 1);
      report_and_stop();
   end
endmodule // test_pmx_port
